// ==== sim/ssc_standby_clock_switch_tb_top.sv ====
// Testbench for the standby and slow clock switch.
// Assumes ssc_pkg and the design module are compiled first.
`timescale 1ns/10ps
`default_nettype none
module ssc_standby_clock_switch_tb_top
   import ssc_pkg::*;
   ;
   localparam int LF = 42;  // Gear clocks per low clock period, rounded up
   logic               clk;
   logic               sys_rst;
   logic [3:0]         avs_address;
   logic               avs_read;
   logic               avs_write;
   logic [31:0]        avs_writedata;
   logic [3:0]         avs_byteenable;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic               lowFreqPin;
   logic [BT_SRCS-1:0] baseTimerSrc;
   logic               watchdogIrq;
   logic               oscPinFunction;
   logic               warmupDone;
   ssc_clk_t           clkCtrl;
   ssc_evt_t           events;
   logic [1:0]         runEn;
   logic [1:0]         oscRun;
   int                 badCount;
   int                 nTests;
   int                 nWake;
   int                 nIrq;
   int                 nResume;
   int                 nRst;
   int                 nWarm;
   int                 holdRun;
   int                 maxHold;
   int                 r0;

   ssc_standby_clock_switch #(.MACHINE_CYCLE_CLKS(4)) dut (
      .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .lowFreqPin(lowFreqPin), .baseTimerSrc(baseTimerSrc),
      .watchdogIrq(watchdogIrq), .oscPinFunction(oscPinFunction),
      .warmupDone(warmupDone), .clkCtrl(clkCtrl), .events(events));

   assign runEn  = {clkCtrl.periphClkEn, clkCtrl.cpuClkEn};
   assign oscRun = {clkCtrl.hiOscRun, clkCtrl.loOscRun};

   initial clk = 1'b0;
   always #2 clk = ~clk;
   initial begin
      lowFreqPin = 1'b0;
      #13;
      forever #83 lowFreqPin = ~lowFreqPin;
   end

   // Event pulse counters and longest main clock stop, sampled mid-cycle
   always @(negedge clk) begin
      if (events.wake === 1'b1) nWake++;
      if (events.irqTake === 1'b1) nIrq++;
      if (events.resumeNext === 1'b1) nResume++;
      if (events.clkRst === 1'b1) nRst++;
      if (events.warmStart === 1'b1) nWarm++;
      if (clkCtrl.hold === 1'b1) holdRun++;
      else holdRun = 0;
      if (holdRun > maxHold) maxHold = holdRun;
   end

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One Avalon access; entered just after a rising edge
   task automatic xfer(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, a, {24'h0, d}, r);
   endtask

   task automatic rdChk(input string nm, input logic [3:0] a,
                        input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(nm, exp & m, r & m);
   endtask

   task automatic waitMain(input logic exp, input int lim, input int n0);
      int n;
      n = n0;
      while (clkCtrl.mainSel !== exp && n < lim + 20) begin
         @(negedge clk);
         n++;
      end
      chk("mainSel", {31'h0, exp}, {31'h0, clkCtrl.mainSel});
      chk("switch in time", 32'h1, 32'(n <= lim));
      @(posedge clk);
   endtask

   task automatic deep(input int sel, input logic en, input logic [7:0] irq,
                       input int expIrq);
      int w0;
      int i0;
      int q0;
      int n;
      w0 = nWake;
      i0 = nIrq;
      q0 = nResume;
      n = 0;
      wr(OFS_BASE_TIMER_CTL, 8'((sel << 1) | en));
      wr(OFS_IRQ_CTRL, irq | 8'h4);
      wr(OFS_SYS_CTRL_TWO, 8'h5);
      rdChk("deep mode", OFS_STATUS, 32'h2, 32'h3);
      chk("deep clocks", 32'h0, 32'(runEn));
      baseTimerSrc <= ~(8'h1 << ((sel + 1) % 8));
      repeat (10) @(posedge clk);
      rdChk("other source", OFS_STATUS, 32'h2, 32'h3);
      baseTimerSrc <= ~(8'h1 << sel);
      while (nWake == w0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      chk("wake", w0 + 1, nWake);
      chk("irq take", i0 + expIrq, nIrq);
      chk("resume next", q0 + 1 - expIrq, nResume);
      rdChk("halt cleared", OFS_SYS_CTRL_TWO, 32'h4, 32'hf);
      rdChk("run again", OFS_STATUS, 32'h1, 32'h3);
      chk("wake clocks", 32'h3, 32'(runEn));
      rdChk("latch", OFS_IRQ_CTRL, {29'h0, en, irq[1:0]}, 32'h7);
      baseTimerSrc <= '1;
      repeat (4) @(posedge clk);
   endtask

   task automatic completeRun;
      $display("Checks %0d, mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #100000;
      badCount++;
      $display("MISMATCH watchdog expected done seen timeout");
      completeRun();
   end

   initial begin
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      baseTimerSrc = '1;
      {watchdogIrq, warmupDone} = 2'h0;
      oscPinFunction = 1'b1;
      {badCount, nTests, nWake, nIrq, nResume, nRst, nWarm} = '0;
      {holdRun, maxHold} = '0;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdChk("reset ctrl", OFS_SYS_CTRL_TWO, 32'h4, 32'hffffffff);
      chk("reset osc", 32'h2, 32'(oscRun));
      rdChk("warmup", OFS_STATUS, 32'h0, 32'h3);
      chk("warmup clocks", 32'h0, 32'(runEn));
      warmupDone <= 1'b1;
      @(posedge clk);
      rdChk("fast run", OFS_STATUS, 32'h1, 32'h3);
      chk("run clocks", 32'h3, 32'(runEn));
      rdChk("unmapped", 4'h2, 32'h0, 32'hffffffff);
      avs_byteenable <= 4'he;
      wr(OFS_SYS_CTRL_TWO, 8'h0);
      avs_byteenable <= 4'hf;
      rdChk("lane 0 off", OFS_SYS_CTRL_TWO, 32'h4, 32'hf);
      $display("Test reset done");
      r0 = nRst;
      wr(OFS_SYS_CTRL_TWO, 8'h0);
      oscPinFunction <= 1'b0;
      wr(OFS_SYS_CTRL_TWO, 8'h4);
      rdChk("hi osc refused", OFS_SYS_CTRL_TWO, 32'h0, 32'hf);
      chk("hi osc off", 32'h0, 32'(oscRun));
      chk("pin clock reset", r0 + 1, nRst);
      oscPinFunction <= 1'b1;
      r0 = nWarm;
      wr(OFS_SYS_CTRL_TWO, 8'h4);
      wr(OFS_SYS_CTRL_TWO, 8'h4);
      chk("warm start once", r0 + 1, nWarm);
      $display("Test oscillator done");
      wr(OFS_SYS_CTRL_TWO, 8'hc);
      chk("osc both run", 32'h3, 32'(oscRun));
      r0 = nRst;
      maxHold = 0;
      wr(OFS_SYS_CTRL_TWO, 8'he);
      wr(OFS_SYS_CTRL_TWO, 8'ha);
      chk("early clear reset", r0 + 1, nRst);
      waitMain(1'b1, 2 + 10 * LF, 5);
      chk("slow stop", 32'h1, 32'(maxHold <= 10 * LF));
      wr(OFS_SYS_CTRL_TWO, 8'he);
      repeat (10) @(posedge clk);
      maxHold = 0;
      wr(OFS_SYS_CTRL_TWO, 8'hc);
      waitMain(1'b0, 8 * LF + 3, 1);
      chk("fast stop", 32'h1, 32'(maxHold <= 2));
      r0 = nRst;
      repeat (12) @(posedge clk);
      wr(OFS_SYS_CTRL_TWO, 8'h4);
      chk("late clear", r0, nRst);
      $display("Test clock switch done");
      watchdogIrq <= 1'b1;
      wr(OFS_SYS_CTRL_TWO, 8'h5);
      rdChk("no deep entry", OFS_STATUS, 32'h1, 32'h3);
      rdChk("halt stays", OFS_SYS_CTRL_TWO, 32'h4, 32'hf);
      watchdogIrq <= 1'b0;
      deep(5, 1'b1, 8'h3, 1);
      deep(2, 1'b0, 8'h0, 0);
      $display("Test deep state done");
      wr(OFS_SYS_CTRL_TWO, 8'hd);
      warmupDone <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdChk("reset warmup", OFS_STATUS, 32'h0, 32'h7f);
      chk("reset osc again", 32'h2, 32'(oscRun));
      warmupDone <= 1'b1;
      @(posedge clk);
      rdChk("reset fast", OFS_STATUS, 32'h1, 32'h7f);
      rdChk("reset ctrl again", OFS_SYS_CTRL_TWO, 32'h4, 32'hf);
      $display("Test reset release done");
      completeRun();
   end
endmodule
`default_nettype wire

// ==== src/ssc_pkg.sv ====
// Package for the standby and slow clock switch block.
// Assumes one system clock (the gear clock) and Avalon-MM register access.
package ssc_pkg;

   // Register byte offsets
   localparam logic [3:0] OFS_SYS_CTRL_TWO   = 4'h0;
   localparam logic [3:0] OFS_BASE_TIMER_CTL = 4'h4;
   localparam logic [3:0] OFS_IRQ_CTRL       = 4'h8;
   localparam logic [3:0] OFS_STATUS         = 4'hc;

   // system_control_two fields
   localparam int BIT_HALT    = 0;
   localparam int BIT_SLOWSEL = 1;
   localparam int BIT_HIOSC   = 2;
   localparam int BIT_LOOSC   = 3;

   // base_timer_control fields
   localparam int BIT_BT_EN   = 0;
   localparam int BIT_BT_SEL  = 1;
   localparam int BT_SEL_W    = 3;
   localparam int BT_SRCS     = 8;

   // irq control fields
   localparam int BIT_MASTER  = 0;
   localparam int BIT_BT_IRQ  = 1;
   localparam int BIT_LATCH   = 2;

   // status fields
   localparam int STAT_MODE   = 0;
   localparam int STAT_PHASE  = 2;
   localparam int STAT_MAIN   = 5;
   localparam int STAT_HOLD   = 6;

   // Timing figures, in periods of the named clock
   localparam int SLOW_SW_GEAR_CYCLES = 2;
   localparam int SLOW_SYNC_LF_MAX    = 10;
   localparam int FAST_SYNC_LF_MAX    = 8;
   localparam int FAST_HOLD_GEAR      = 2;
   localparam int WAIT_MACHINE_CYCLES = 2;
   localparam logic [1:0] DIV4_LAST   = 2'h3;

   typedef enum logic [1:0] {PM_WARMUP, PM_RUN, PM_DEEP} ssc_pmode_t;
   typedef enum logic [2:0] {CK_FAST, CK_TO_SLOW_WAIT, CK_TO_SLOW_SYNC,
                             CK_SLOW, CK_TO_FAST_SYNC,
                             CK_TO_FAST_HOLD} ssc_phase_t;

   // Clock control outputs
   typedef struct packed {
      logic mainSel;
      logic hold;
      logic hiOscRun;
      logic loOscRun;
      logic periphClkEn;
      logic cpuClkEn;
   } ssc_clk_t;

   // One-cycle event outputs
   typedef struct packed {
      logic wake;
      logic resumeNext;
      logic irqTake;
      logic clkRst;
      logic warmStart;
   } ssc_evt_t;

   typedef struct packed {
      logic               ack;
      logic [31:0]        rdata;
      ssc_pmode_t         mode;
      ssc_phase_t         phase;
      logic [1:0]         phCnt;
      logic [3:0]         lfHeld;
      logic [7:0]         machCnt;
      logic [1:0]         div;
      logic               halt;
      logic               slowSel;
      logic               hiOscEn;
      logic               loOscEn;
      logic               btEn;
      logic [BT_SEL_W-1:0] btSel;
      logic               masterEn;
      logic               btIrqEn;
      logic               btLatch;
      logic               mainSel;
      logic               hold;
      logic               lf1;
      logic               lf2;
      logic               lfPrev;
      logic [BT_SRCS-1:0] bt1;
      logic [BT_SRCS-1:0] bt2;
      logic [BT_SRCS-1:0] btPrev;
      ssc_evt_t           ev;
   } ssc_state_t;

endpackage

// ==== src/ssc_standby_clock_switch.sv ====
// Deep idle/sleep control and gear/slow main clock switch.
// Assumes clk is the gear clock; oscillator and base timer pins are async.
`timescale 1ns/10ps
`default_nettype none
module ssc_standby_clock_switch
   import ssc_pkg::*;
#(
   parameter int MACHINE_CYCLE_CLKS = 4
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // Avalon-MM slave
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   // Asynchronous clock sources
   input  wire logic               lowFreqPin,
   input  wire logic [BT_SRCS-1:0] baseTimerSrc,
   // Same-clock system inputs
   input  wire logic               watchdogIrq,
   input  wire logic               oscPinFunction,
   input  wire logic               warmupDone,
   // Clock control and events
   output ssc_clk_t                clkCtrl,
   output ssc_evt_t                events
);

   localparam int MACH_WAIT_I = WAIT_MACHINE_CYCLES * MACHINE_CYCLE_CLKS;
   localparam logic [7:0] MACH_WAIT = 8'(MACH_WAIT_I);
   localparam logic [1:0] SLOW_WAIT_LAST = 2'(SLOW_SW_GEAR_CYCLES - 1);
   localparam logic [1:0] FAST_HOLD_LAST = 2'(FAST_HOLD_GEAR - 1);

   if (MACHINE_CYCLE_CLKS < 1 || MACH_WAIT_I > 255) begin : cycleCheck
      $error("MACHINE_CYCLE_CLKS out of range");
   end
   if (BT_SRCS != (1 << BT_SEL_W)) begin : srcCheck
      $error("base timer source count mismatch");
   end

   ssc_state_t s;
   ssc_state_t next_s;

   logic       req;
   logic       wrTake;
   logic       lfFall;
   logic       btFall;
   logic       quarter;
   logic [7:0] wd;
   logic       wrCtl2;
   logic       wrBt;
   logic       wrIrq;

   assign req     = avs_read | avs_write;
   assign wrTake  = avs_write & s.ack & avs_byteenable[0];
   assign wd      = avs_writedata[7:0];
   assign wrCtl2  = wrTake && avs_address == OFS_SYS_CTRL_TWO;
   assign wrBt    = wrTake && avs_address == OFS_BASE_TIMER_CTL;
   assign wrIrq   = wrTake && avs_address == OFS_IRQ_CTRL;
   // Edges seen only after the second sync stage
   assign lfFall  = s.lfPrev & ~s.lf2;
   assign btFall  = s.btPrev[s.btSel] & ~s.bt2[s.btSel];
   assign quarter = lfFall && s.div == DIV4_LAST;

   assign avs_waitrequest = req & ~s.ack;
   assign avs_readdata    = s.rdata;

   always_comb begin
      next_s = s;
      next_s.ev = '0;

      // Synchronisers
      next_s.lf1    = lowFreqPin;
      next_s.lf2    = s.lf1;
      next_s.lfPrev = s.lf2;
      next_s.bt1    = baseTimerSrc;
      next_s.bt2    = s.bt1;
      next_s.btPrev = s.bt2;
      if (lfFall) begin
         next_s.div = s.div + 2'h1;
      end
      if (s.machCnt != 8'h00) begin
         next_s.machCnt = s.machCnt - 8'h01;
      end

      // Bus handshake, one wait state
      next_s.ack = req & ~s.ack;
      if (req && !s.ack) begin
         next_s.rdata = '0;
         case (avs_address)
            OFS_SYS_CTRL_TWO: begin
               next_s.rdata[BIT_HALT]    = s.halt;
               next_s.rdata[BIT_SLOWSEL] = s.slowSel;
               next_s.rdata[BIT_HIOSC]   = s.hiOscEn;
               next_s.rdata[BIT_LOOSC]   = s.loOscEn;
            end
            OFS_BASE_TIMER_CTL: begin
               next_s.rdata[BIT_BT_EN] = s.btEn;
               next_s.rdata[BIT_BT_SEL +: BT_SEL_W] = s.btSel;
            end
            OFS_IRQ_CTRL: begin
               next_s.rdata[BIT_MASTER] = s.masterEn;
               next_s.rdata[BIT_BT_IRQ] = s.btIrqEn;
               next_s.rdata[BIT_LATCH]  = s.btLatch;
            end
            OFS_STATUS: begin
               next_s.rdata[STAT_MODE +: $bits(ssc_pmode_t)]  = s.mode;
               next_s.rdata[STAT_PHASE +: $bits(ssc_phase_t)] = s.phase;
               next_s.rdata[STAT_MAIN] = s.mainSel;
               next_s.rdata[STAT_HOLD] = s.hold;
            end
            default: next_s.rdata = '0;
         endcase
      end

      // system_control_two writes
      if (wrCtl2) begin
         if (wd[BIT_HALT] && s.mode == PM_RUN && !watchdogIrq) begin
            next_s.halt = 1'b1;
            next_s.mode = PM_DEEP;
         end
         if (wd[BIT_SLOWSEL] != s.slowSel) begin
            next_s.slowSel = wd[BIT_SLOWSEL];
            next_s.machCnt = MACH_WAIT;
         end
         if (wd[BIT_HIOSC]) begin
            if (!oscPinFunction) begin
               next_s.ev.clkRst = 1'b1;
            end else if (!s.hiOscEn) begin
               next_s.hiOscEn = 1'b1;
               next_s.ev.warmStart = 1'b1;
            end
         end else if (s.hiOscEn) begin
            next_s.hiOscEn = 1'b0;
            if (s.machCnt != 8'h00) begin
               next_s.ev.clkRst = 1'b1;
            end
         end
         if (wd[BIT_LOOSC] && !s.loOscEn) begin
            next_s.loOscEn = 1'b1;
            next_s.ev.warmStart = 1'b1;
         end else if (!wd[BIT_LOOSC] && s.loOscEn) begin
            next_s.loOscEn = 1'b0;
            if (s.machCnt != 8'h00) begin
               next_s.ev.clkRst = 1'b1;
            end
         end
      end
      if (wrBt) begin
         next_s.btEn  = wd[BIT_BT_EN];
         next_s.btSel = wd[BIT_BT_SEL +: BT_SEL_W];
      end
      if (wrIrq) begin
         next_s.masterEn = wd[BIT_MASTER];
         next_s.btIrqEn  = wd[BIT_BT_IRQ];
         if (wd[BIT_LATCH]) begin
            next_s.btLatch = 1'b0;
         end
      end

      // Power mode
      case (s.mode)
         PM_WARMUP: begin
            if (warmupDone) begin
               next_s.mode = PM_RUN;
            end
         end
         PM_RUN: begin
         end
         PM_DEEP: begin
            if (btFall) begin
               next_s.mode    = PM_RUN;
               next_s.halt    = 1'b0;
               next_s.ev.wake = 1'b1;
               if (s.btEn) begin
                  next_s.btLatch = 1'b1;
               end
               if (s.masterEn && s.btIrqEn && s.btEn) begin
                  next_s.ev.irqTake = 1'b1;
               end else begin
                  next_s.ev.resumeNext = 1'b1;
               end
            end
         end
         default: next_s.mode = PM_WARMUP;
      endcase

      // Main clock switch; phase is kept across deep states
      if (lfFall && s.hold) begin
         next_s.lfHeld = s.lfHeld + 4'h1;
      end
      case (s.phase)
         CK_FAST: begin
            if (s.slowSel) begin
               next_s.phase = CK_TO_SLOW_WAIT;
               next_s.phCnt = 2'h0;
            end
         end
         CK_TO_SLOW_WAIT: begin
            next_s.phCnt = s.phCnt + 2'h1;
            if (s.phCnt == SLOW_WAIT_LAST) begin
               next_s.phase  = CK_TO_SLOW_SYNC;
               next_s.hold   = 1'b1;
               next_s.lfHeld = 4'h0;
            end
         end
         CK_TO_SLOW_SYNC: begin
            if (quarter) begin
               next_s.phase   = CK_SLOW;
               next_s.mainSel = 1'b1;
               next_s.hold    = 1'b0;
            end
         end
         CK_SLOW: begin
            if (!s.slowSel) begin
               next_s.phase = CK_TO_FAST_SYNC;
            end
         end
         CK_TO_FAST_SYNC: begin
            if (quarter) begin
               next_s.phase = CK_TO_FAST_HOLD;
               next_s.hold  = 1'b1;
               next_s.phCnt = 2'h0;
            end
         end
         CK_TO_FAST_HOLD: begin
            next_s.phCnt = s.phCnt + 2'h1;
            if (s.phCnt == FAST_HOLD_LAST) begin
               next_s.phase   = CK_FAST;
               next_s.mainSel = 1'b0;
               next_s.hold    = 1'b0;
            end
         end
         default: next_s.phase = CK_FAST;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s         <= '0;
         s.hiOscEn <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   always_comb begin
      clkCtrl.mainSel     = s.mainSel;
      clkCtrl.hold        = s.hold;
      clkCtrl.hiOscRun    = s.hiOscEn;
      clkCtrl.loOscRun    = s.loOscEn;
      clkCtrl.periphClkEn = s.mode == PM_RUN;
      clkCtrl.cpuClkEn    = s.mode == PM_RUN && !s.hold;
   end
   assign events = s.ev;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_enter;
      wrCtl2 && wd[BIT_HALT] && s.mode == PM_RUN && !watchdogIrq
         |=> s.mode == PM_DEEP && s.halt;
   endproperty
   a_enter: assert property (p_enter) else $error("no deep entry");
   property p_wdog;
      wrCtl2 && wd[BIT_HALT] && s.mode == PM_RUN && watchdogIrq
         |=> s.mode == PM_RUN && !s.halt;
   endproperty
   a_wdog: assert property (p_wdog) else $error("entered with wdog");
   property p_wake;
      s.mode == PM_DEEP && btFall |=> s.mode == PM_RUN && !s.halt
         && events.wake && $stable(s.phase);
   endproperty
   a_wake: assert property (p_wake) else $error("bad release");
   property p_stay;
      s.mode == PM_DEEP && !btFall |=> s.mode == PM_DEEP;
   endproperty
   a_stay: assert property (p_stay) else $error("spurious release");
   property p_latch;
      s.mode == PM_DEEP && btFall && s.btEn |=> s.btLatch;
   endproperty
   a_latch: assert property (p_latch) else $error("latch not set");
   property p_resume;
      s.mode == PM_DEEP && btFall && !s.masterEn && !s.btIrqEn && !s.btEn
         |=> events.resumeNext && !events.irqTake;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume");
   property p_irq;
      s.mode == PM_DEEP && btFall && s.masterEn && s.btIrqEn && s.btEn
         |=> events.irqTake && !events.resumeNext;
   endproperty
   a_irq: assert property (p_irq) else $error("no irq take");
   property p_warm;
      s.mode == PM_WARMUP |-> !s.mainSel && !clkCtrl.cpuClkEn;
   endproperty
   a_warm: assert property (p_warm) else $error("run in warmup");
   property p_slowgo;
      s.phase == CK_FAST && s.slowSel
         |=> s.phase == CK_TO_SLOW_WAIT [*2] ##1 s.phase == CK_TO_SLOW_SYNC;
   endproperty
   a_slowgo: assert property (p_slowgo) else $error("slow wait");
   property p_slowhold;
      s.hold && !s.mainSel |-> s.lfHeld <= 4'(SLOW_SYNC_LF_MAX);
   endproperty
   a_slowhold: assert property (p_slowhold) else $error("long hold");
   property p_early;
      wrCtl2 && s.machCnt != 8'h00
         && ((!wd[BIT_HIOSC] && s.hiOscEn) || (!wd[BIT_LOOSC] && s.loOscEn))
         |=> events.clkRst;
   endproperty
   a_early: assert property (p_early) else $error("no clock reset");
   property p_fast;
      s.phase == CK_TO_FAST_SYNC && quarter
         |=> s.hold ##2 !s.hold && !s.mainSel;
   endproperty
   a_fast: assert property (p_fast) else $error("fast switch");
   property p_fasthold;
      s.hold && s.mainSel |-> s.phCnt <= FAST_HOLD_LAST;
   endproperty
   a_fasthold: assert property (p_fasthold) else $error("hold");

   property p_pinfn;
      wrCtl2 && wd[BIT_HIOSC] && !oscPinFunction |=> events.clkRst;
   endproperty
   a_pinfn: assert property (p_pinfn) else $error("pin reset");

   property p_rewr;
      wrCtl2 && wd[BIT_HIOSC] && s.hiOscEn && !(wd[BIT_LOOSC] && !s.loOscEn)
         |=> !events.warmStart;
   endproperty
   a_rewr: assert property (p_rewr) else $error("warm restart");

   c_deep:  cover property (s.mode == PM_DEEP ##[1:50] events.irqTake);
   c_slow:  cover property (s.phase == CK_SLOW);
   c_fast:  cover property (s.mainSel ##[1:200] !s.mainSel);
   c_crst:  cover property (events.clkRst);

endmodule
`default_nettype wire
